// >>> src/pir_pkg.sv
// Purpose: Constants and types shared by the interrupt recognition block
// Assumes: 20 MHz system clock, synchronous active-high reset
// Notes: Register indices are word offsets on the plain register port
//
// Functional notes
// - Seven priority levels, seven autovectors, 200 assignable vectors supported.
// - Three-bit mask; requests at or below mask level, other than level seven, are not recognized.
// - Seven request lines; line one lowest priority, line seven highest.
// - External pin requests handled exactly like internal module requests.
// - Level seven is recognized even when the mask is seven.
// - Level seven detected on a falling transition or a mask write, not merely while held.
// - Writing the mask while level seven is low raises a new request.
// - Requests sampled each clock; valid after two consecutive asserted samples.
// - Valid requests stay pending until an instruction boundary or handler end.
// - Vector table base is zero after reset, relocatable by software write.
// - Vector number scaled into table offset gives the handler fetch address.
// - Acknowledge cycle ends with autovector or sized transfer acknowledge; neither if sized with arbitration zero.
// - Arbitration number resets to zero; zero takes no part in arbitration.
// - Master reset loads the priority mask with seven.
package pir_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_MASK = 4'h0;
	localparam logic [3:0] REG_VBASE = 4'h1;
	localparam logic [3:0] REG_ARB = 4'h2;
	localparam logic [3:0] REG_PEND = 4'h3;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_IEN = 4'h5;
	localparam logic [3:0] REG_ACKCFG = 4'h6;
	localparam logic [2:0] MASK_RESET = 3'h7;
	localparam logic [31:0] VBASE_RESET = 32'h00000000;
	localparam logic [3:0] ARB_RESET = 4'h0;
	localparam logic [7:0] AUTOVEC_BASE = 8'h18;
	localparam logic [7:0] USER_VEC_FIRST = 8'h38;
	localparam int NUM_USER_VEC = 200;
	localparam int NUM_LEVELS = 7;
	localparam int VALID_SAMPLES = 2;
	localparam logic [7:0] SPURIOUS_VEC = 8'h18;
	// Status bit positions
	localparam int ST_NMI = 0;
	localparam int ST_ACK = 1;
	localparam int ST_SPUR = 2;
	typedef enum logic [1:0] {
		PIR_IDLE = 2'b00,
		PIR_ACK = 2'b01,
		PIR_FETCH = 2'b10
	} pir_state_e;
endpackage

// >>> src/pir_req_if.sv
`timescale 1ns/1ns
// Purpose: Carries filtered request levels from the input filter to the core
// Assumes: One clock domain
// Notes: Level seven arrives as an edge event, the others as levels
interface pir_req_if;
	logic [7:1] valid;
	logic nmi_edge;
	modport filt (output valid, output nmi_edge);
	modport core (input valid, input nmi_edge);
endinterface // pir_req_if

// >>> src/pir_filter.sv
`timescale 1ns/1ns
// Purpose: Two-sample validation of active-low request lines
// Assumes: Request lines synchronous to clk
// Notes: A glitch of one clock never reaches the priority logic
module pir_filter
	import pir_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:1] req_n,
	pir_req_if.filt rq
);
	logic [7:1] s1_q;
	logic [7:1] s2_q;
	logic [7:1] val_q;
	logic [7:1] val_d;
	logic top_prev_q;

	assign val_d = s1_q & s2_q;
	assign rq.valid = val_q;
	assign rq.nmi_edge = val_q[7] & ~top_prev_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 7'h00;
			s2_q <= 7'h00;
			val_q <= 7'h00;
			top_prev_q <= 1'b0;
		end else begin
			s1_q <= ~req_n;
			s2_q <= s1_q;
			val_q <= val_d;
			top_prev_q <= val_q[7];
		end
	end
endmodule // pir_filter

// >>> src/pir_vector.sv
`timescale 1ns/1ns
// Purpose: Vector number to table address
// Assumes: Four-byte vectors
// Notes: Pure combinational
module pir_vector
	import pir_pkg::*;
(
	input wire logic [31:0] base,
	input wire logic [7:0] vec_num,
	output logic [31:0] addr
);
	assign addr = base + {22'h000000, vec_num, 2'b00};
endmodule // pir_vector

// >>> src/pir_top.sv
`timescale 1ns/1ns
// Purpose: Interrupt request recognition, prioritisation and acknowledge
// Assumes: Requests synchronous to clk; CPU side signals boundary and ack cycle
// Notes: One acknowledge at a time; level seven edge is latched until acked
module pir_top
	import pir_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:1] req_n,
	input wire logic boundary,
	input wire logic ack_start,
	input wire logic [3:0] ack_arb,
	input wire logic [7:0] ack_vec,
	input wire logic ack_vec_valid,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq_pending,
	output logic [2:0] irq_level,
	output logic ack_busy,
	output logic auto_vector_ack,
	output logic sized_transfer_ack,
	output logic fetch_valid,
	output logic [31:0] fetch_addr,
	output logic [7:0] fetch_vec,
	output logic intr
);
	pir_req_if rq();
	pir_state_e st_q;
	pir_state_e st_d;
	logic [2:0] priority_mask_field_q;
	logic [31:0] vector_table_base_q;
	logic [3:0] arbitration_number_field_q;
	logic top_latched_q;
	logic [2:0] ack_lvl_q;
	logic [2:0] stat_q;
	logic [2:0] ien_q;
	logic ack_auto_cfg_q;
	logic auto_vector_ack_q;
	logic sized_transfer_ack_q;
	logic fetch_valid_q;
	logic [31:0] fetch_addr_q;
	logic [7:0] fetch_vec_q;
	logic [31:0] rdata_q;
	logic [31:0] vaddr;
	logic [7:0] sel_vec;
	logic [7:1] eligible;
	logic [2:0] best_lvl;
	logic any_elig;
	logic wr_mask;
	logic [2:0] stat_set;
	logic [2:0] stat_clr;
	logic arb_ok;
	logic take_ack;
	logic [31:0] rd_mux;

	pir_filter u_filt (
		.clk(clk),
		.rst(rst),
		.req_n(req_n),
		.rq(rq.filt)
	);

	pir_vector u_vec (
		.base(vector_table_base_q),
		.vec_num(sel_vec),
		.addr(vaddr)
	);

	// Highest set bit of a seven-level vector
	function automatic logic [2:0] top_level(input logic [7:1] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 1; i <= NUM_LEVELS; i++) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	assign wr_mask = reg_wr && (reg_addr == REG_MASK);

	// Levels one to six follow the line level and the mask; seven uses its latch
	genvar g;
	generate
		for (g = 1; g < 7; g++) begin : g_elig
			assign eligible[g] = rq.valid[g] && (3'(g) > priority_mask_field_q);
		end
	endgenerate
	assign eligible[7] = top_latched_q;

	assign best_lvl = top_level(eligible);
	assign any_elig = |eligible;
	assign arb_ok = arbitration_number_field_q != 4'h0;
	// Acknowledge starts only at a boundary, otherwise requests wait
	assign take_ack = (st_q == PIR_IDLE) && any_elig && boundary && ack_start;

	// Auto vector picks the fixed slot per level, else the supplied number
	assign sel_vec = (ack_auto_cfg_q || !ack_vec_valid) ?
		AUTOVEC_BASE + {5'h00, ack_lvl_q} : ack_vec;

	always_comb begin
		st_d = st_q;
		case (st_q)
			PIR_IDLE: begin
				if (take_ack) begin
					st_d = PIR_ACK;
				end
			end
			PIR_ACK: begin
				st_d = PIR_FETCH;
			end
			PIR_FETCH: begin
				st_d = PIR_IDLE;
			end
			default: begin
				st_d = PIR_IDLE;
			end
		endcase
	end

	// Set wins over the write-one clear
	assign stat_set[ST_NMI] = rq.nmi_edge || (wr_mask && rq.valid[7]);
	assign stat_set[ST_ACK] = st_q == PIR_ACK;
	assign stat_set[ST_SPUR] = (st_q == PIR_ACK) && !arb_ok && !ack_auto_cfg_q;
	assign stat_clr = (reg_wr && reg_addr == REG_STAT) ? reg_wdata[2:0] : 3'h0;

	always_comb begin
		rd_mux = 32'h00000000;
		case (reg_addr)
			REG_MASK: rd_mux = {29'h0, priority_mask_field_q};
			REG_VBASE: rd_mux = vector_table_base_q;
			REG_ARB: rd_mux = {28'h0, arbitration_number_field_q};
			REG_PEND: rd_mux = {21'h0, best_lvl, 1'b0, eligible};
			REG_STAT: rd_mux = {29'h0, stat_q};
			REG_IEN: rd_mux = {29'h0, ien_q};
			REG_ACKCFG: rd_mux = {31'h0, ack_auto_cfg_q};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= PIR_IDLE;
			priority_mask_field_q <= MASK_RESET;
			vector_table_base_q <= VBASE_RESET;
			arbitration_number_field_q <= ARB_RESET;
			ien_q <= 3'h0;
			ack_auto_cfg_q <= 1'b1;
		end else begin
			st_q <= st_d;
			if (wr_mask) begin
				priority_mask_field_q <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == REG_VBASE) begin
				vector_table_base_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == REG_ARB) begin
				arbitration_number_field_q <= reg_wdata[3:0];
			end
			if (reg_wr && reg_addr == REG_IEN) begin
				ien_q <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == REG_ACKCFG) begin
				ack_auto_cfg_q <= reg_wdata[0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			top_latched_q <= 1'b0;
			ack_lvl_q <= 3'h0;
			stat_q <= 3'h0;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
			if (take_ack) begin
				ack_lvl_q <= best_lvl;
			end
			// Edge or mask rewrite arms level seven; its acknowledge disarms it
			if (rq.nmi_edge || (wr_mask && rq.valid[7])) begin
				top_latched_q <= 1'b1;
			end else if (take_ack && best_lvl == 3'h7) begin
				top_latched_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			auto_vector_ack_q <= 1'b0;
			sized_transfer_ack_q <= 1'b0;
			fetch_valid_q <= 1'b0;
			fetch_addr_q <= 32'h00000000;
			fetch_vec_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			auto_vector_ack_q <= (st_q == PIR_ACK) && (ack_auto_cfg_q || !ack_vec_valid);
			sized_transfer_ack_q <= (st_q == PIR_ACK) && !ack_auto_cfg_q && ack_vec_valid && arb_ok;
			fetch_valid_q <= st_q == PIR_ACK;
			if (st_q == PIR_ACK) begin
				fetch_addr_q <= vaddr;
				fetch_vec_q <= sel_vec;
			end
			rdata_q <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq_pending = any_elig;
	assign irq_level = best_lvl;
	assign ack_busy = st_q != PIR_IDLE;
	assign auto_vector_ack = auto_vector_ack_q;
	assign sized_transfer_ack = sized_transfer_ack_q;
	assign fetch_valid = fetch_valid_q;
	assign fetch_addr = fetch_addr_q;
	assign fetch_vec = fetch_vec_q;
	assign intr = |(stat_q & ien_q);
endmodule // pir_top

// >>> testbench/pir_checker.sv
// Purpose: Port-level checks for the interrupt recognition block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to pir_top from the testbench top file
`timescale 1ns/1ns
module pir_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:1] req_n,
	input wire logic boundary,
	input wire logic ack_start,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic irq_pending,
	input wire logic [2:0] irq_level,
	input wire logic ack_busy,
	input wire logic auto_vector_ack,
	input wire logic sized_transfer_ack,
	input wire logic fetch_valid,
	input wire logic intr
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_take;
		boundary && ack_start && irq_pending && !ack_busy;
	endsequence
	sequence s_walk;
		ack_busy ##1 (ack_busy && fetch_valid) ##1 !ack_busy;
	endsequence
	property p_walk; s_take |=> s_walk; endproperty
	a_walk: assert property (p_walk) else $error("ack walk broken");
	// Level 1 only sees line 1, so two low samples must precede it
	// The level register lags the two line samples by one edge
	property p_filt; $rose(irq_level == 3'h1) |-> !$past(req_n[1], 2) && !$past(req_n[1], 3); endproperty
	a_filt: assert property (p_filt) else $error("level 1 without two low samples");
	property p_ackx; !(auto_vector_ack && sized_transfer_ack); endproperty
	a_ackx: assert property (p_ackx) else $error("both acks at once");
	property p_fetch; fetch_valid |-> auto_vector_ack || sized_transfer_ack; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch without termination");
	property p_pulse; auto_vector_ack |=> !auto_vector_ack; endproperty
	a_pulse: assert property (p_pulse) else $error("auto ack longer than one cycle");
	property p_rd; reg_rdata != 32'h0 |-> $past(reg_rd); endproperty
	a_rd: assert property (p_rd) else $error("read data outside read slot");
	property p_lvl; irq_pending == (irq_level != 3'h0); endproperty
	a_lvl: assert property (p_lvl) else $error("pending and level disagree");
	property p_rst; $fell(rst) |-> irq_level == 3'h0 && !intr; endproperty
	a_rst: assert property (p_rst) else $error("request visible at reset release");
endmodule // pir_checker

// >>> testbench/pir_src_model.sv
// Purpose: Interrupting sources driving the active-low request lines
// Assumes: Autovector mode, so the low vector bits give the acked level
// Notes: A stuck source ignores acknowledges, as a held line would
`timescale 1ns/1ns
module pir_src_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:1] want,
	input wire logic [7:1] drop,
	input wire logic stick,
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_vec,
	output logic [7:1] req_n
);
	logic [7:0] rel;
	assign rel = (fetch_valid && !stick) ? (8'h01 << fetch_vec[2:0]) : 8'h00;
	always_ff @(posedge clk) begin
		if (rst) begin
			req_n <= 7'h7f;
		end else begin
			req_n <= (req_n & ~want) | drop | rel[7:1];
		end
	end
endmodule // pir_src_model

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the interrupt recognition block
// Assumes: Register reads return data one cycle after the strobe
// Notes: Sources held by pir_src_model; responder ties its inputs
`timescale 1ns/1ns
module tb
	import pir_pkg::*;
;
	logic clk, rst, boundary, ack_start, reg_wr, reg_rd, stick, vec_v;
	logic [7:1] req_n, want, drop;
	logic [ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, fetch_addr;
	logic irq_pending, ack_busy, auto_vector_ack, sized_transfer_ack, fetch_valid, intr;
	logic [2:0] irq_level;
	logic [7:0] fetch_vec;
	int err_total;
	int tests_run;
	pir_top i_pir_top (.clk, .rst, .req_n, .boundary, .ack_start, .ack_arb(4'h3), .ack_vec(8'h44),
		.ack_vec_valid(vec_v), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_pending,
		.irq_level, .ack_busy, .auto_vector_ack, .sized_transfer_ack, .fetch_valid, .fetch_addr,
		.fetch_vec, .intr);
	pir_src_model i_pir_src_model (.clk, .rst, .want, .drop, .stick, .fetch_valid, .fetch_vec, .req_n);
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task pulse(input logic [7:1] b);
		@(posedge clk);
		want <= b;
		@(posedge clk);
		want <= 7'h00;
	endtask
	// Boundary is offered for one cycle only, so a late take shows up as a miss
	task ack;
		@(posedge clk);
		boundary <= 1'b1;
		ack_start <= 1'b1;
		@(posedge clk);
		boundary <= 1'b0;
		ack_start <= 1'b0;
		repeat (6) begin
			@(posedge clk);
			#1;
			if (fetch_valid === 1'b1) break;
		end
		// Sized mode is only entered with a non-zero arbitration number
		chk(auto_vector_ack, !vec_v);
		chk(sized_transfer_ack, vec_v);
	endtask
	task t_reset;
		rd(REG_MASK, 32'h7);
		rd(REG_VBASE, 32'h0);
		rd(REG_ARB, 32'h0);
		rd(4'hf, 32'h0);
		chk(irq_level, 3'h0);
		$display("t_reset done");
	endtask
	task t_prio;
		pulse(7'h04);
		cyc(4);
		chk(irq_pending, 1'b0);
		wr(REG_MASK, 32'h0);
		cyc(1);
		chk(irq_level, 3'h3);
		wr(REG_MASK, 32'h3);
		cyc(1);
		chk(irq_pending, 1'b0);
		wr(REG_MASK, 32'h2);
		pulse(7'h10);
		cyc(4);
		chk(irq_level, 3'h5);
		$display("t_prio done");
	endtask
	task t_ack;
		wr(REG_VBASE, 32'h1000);
		ack;
		chk(fetch_addr, 32'h1000 + 4 * (32'(AUTOVEC_BASE) + 5));
		cyc(4);
		chk(irq_level, 3'h3);
		ack;
		chk(fetch_vec, AUTOVEC_BASE + 8'h03);
		cyc(4);
		chk(irq_pending, 1'b0);
		rd(REG_VBASE, 32'h1000);
		$display("t_ack done");
	endtask
	task t_nmi;
		wr(REG_MASK, 32'h7);
		stick <= 1'b1;
		pulse(7'h40);
		cyc(4);
		chk(irq_level, 3'h7);
		wr(REG_IEN, 32'h1);
		cyc(1);
		chk(intr, 1'b1);
		ack;
		cyc(4);
		chk(irq_pending, 1'b0);
		wr(REG_STAT, 32'h7);
		cyc(1);
		chk(intr, 1'b0);
		wr(REG_MASK, 32'h7);
		cyc(2);
		chk(irq_level, 3'h7);
		chk(intr, 1'b1);
		wr(REG_IEN, 32'h0);
		cyc(1);
		chk(intr, 1'b0);
		stick <= 1'b0;
		ack;
		cyc(4);
		chk(irq_pending, 1'b0);
		$display("t_nmi done");
	endtask
	task t_glitch;
		wr(REG_MASK, 32'h0);
		@(posedge clk);
		want <= 7'h02;
		@(posedge clk);
		want <= 7'h00;
		drop <= 7'h02;
		@(posedge clk);
		drop <= 7'h00;
		cyc(4);
		chk(irq_pending, 1'b0);
		pulse(7'h01);
		cyc(4);
		chk(irq_level, 3'h1);
		ack;
		$display("t_glitch done");
	endtask
	task t_sized;
		wr(REG_ARB, 32'h3);
		wr(REG_ACKCFG, 32'h0);
		vec_v <= 1'b1;
		pulse(7'h08);
		cyc(4);
		ack;
		chk(fetch_vec, 8'h44);
		chk(fetch_addr, 32'h1110);
		cyc(4);
		chk(irq_pending, 1'b0);
		vec_v <= 1'b0;
		$display("t_sized done");
	endtask
	task t_rerst;
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rd(REG_MASK, 32'h7);
		rd(REG_VBASE, 32'h0);
		rd(REG_ARB, 32'h0);
		rd(REG_ACKCFG, 32'h1);
		$display("t_rerst done");
	endtask
	task give_verdict;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		give_verdict;
	end
	initial begin
		{rst, boundary, ack_start, reg_wr, reg_rd, stick} = 6'h20;
		want = 7'h00;
		drop = 7'h00;
		vec_v = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_prio;
		t_ack;
		t_nmi;
		t_glitch;
		t_sized;
		t_rerst;
		give_verdict;
	end
endmodule // tb
bind pir_top pir_checker i_pir_checker (.*);
